// [shared/pvr_defines.vh]
// Constants for the amplifier output-stage configuration block
`ifndef PVR_DEFINES_VH
`define PVR_DEFINES_VH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define PVR_IDX_SYS_CTRL2     6'h05
`define PVR_IDX_MASTER_VOL    6'h07
`define PVR_IDX_CH1_VOL       6'h08
`define PVR_IDX_CH2_VOL       6'h09
`define PVR_IDX_CH3_VOL       6'h0A
`define PVR_IDX_RAMP_CFG      6'h0E
`define PVR_IDX_DUTY_CEIL     6'h10
`define PVR_IDX_DELAY_CH1     6'h11
`define PVR_IDX_DELAY_CH2     6'h12
`define PVR_IDX_DELAY_CH1_INV 6'h13
`define PVR_IDX_DELAY_CH2_INV 6'h14
`define PVR_IDX_STOP_GROUP    6'h19

// ****************************************************************
// Reset values
// ****************************************************************
`define PVR_RST_SYS_CTRL2     8'h40
`define PVR_RST_MASTER_VOL    8'hFF
`define PVR_RST_CH_VOL        8'h30
`define PVR_RST_RAMP_CFG      8'h01
`define PVR_RST_DUTY_CEIL     8'h02
`define PVR_RST_DELAY_A       8'hAC
`define PVR_RST_DELAY_B       8'h54
`define PVR_RST_STOP_GROUP    8'h30
`define PVR_MUTE_CODE         8'hFF

// ****************************************************************
// Field positions
// ****************************************************************
`define PVR_SC2_SHUTDOWN      6
`define PVR_SC2_GROUP_OFF     5
`define PVR_RC_SUB_SEL        6
`define PVR_RC_CH3_SEL        5
`define PVR_RC_SLEW_RSVD      2
`define PVR_RAMP_CFG_MASK     8'h67
`define PVR_DUTY_MASK         8'h07
`define PVR_DELAY_MASK        8'hFC

// ****************************************************************
// Ramp lengths and timing
// ****************************************************************
`define PVR_STEPS_512         12'd512
`define PVR_STEPS_1024        12'd1024
`define PVR_STEPS_2048        12'd2048
`define PVR_STEPS_256         12'd256
`define PVR_CLK_NS            4
`define PVR_STEP_8K_US10      1250
`define PVR_STEP_11K_US10     907
`define PVR_STEP_12K_US10     833
`define PVR_FAM_8K            2'b00
`define PVR_FAM_11K           2'b01

// ****************************************************************
// AXI responses
// ****************************************************************
`define PVR_RESP_OKAY         2'b00
`define PVR_RESP_SLVERR       2'b10

`endif

// [hw/pvr_ramp_timer.v]
// Volume ramp pacing: step enable divider and step counter
`default_nettype none
module pvr_ramp_timer #(
  parameter STEP_W = 16,
  parameter CNT_W  = 12
) (
  input  wire              aclk,
  input  wire              aresetn,
  input  wire [STEP_W-1:0] step_cycles,
  input  wire [CNT_W-1:0]  step_total,
  input  wire              start,
  output wire              step_pulse,
  output wire              busy,
  output wire [CNT_W-1:0]  steps_left
);
  reg [STEP_W-1:0] div_ff;
  reg [CNT_W-1:0]  left_ff;
  reg              pulse_ff;
  wire             div_done;

  assign div_done   = (div_ff == {STEP_W{1'b0}});
  assign step_pulse = pulse_ff;
  assign busy       = (left_ff != {CNT_W{1'b0}});
  assign steps_left = left_ff;

  // ****************************************************************
  // A new target restarts the whole ramp rather than finishing the old one
  // ****************************************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      div_ff   <= {STEP_W{1'b0}};
      left_ff  <= {CNT_W{1'b0}};
      pulse_ff <= 1'b0;
    end else if (start) begin
      div_ff   <= step_cycles - {{(STEP_W-1){1'b0}}, 1'b1};
      left_ff  <= step_total;
      pulse_ff <= 1'b0;
    end else if (busy && div_done) begin
      div_ff   <= step_cycles - {{(STEP_W-1){1'b0}}, 1'b1};
      left_ff  <= left_ff - {{(CNT_W-1){1'b0}}, 1'b1};
      pulse_ff <= 1'b1;
    end else begin
      div_ff   <= busy ? div_ff - {{(STEP_W-1){1'b0}}, 1'b1} : div_ff;
      pulse_ff <= 1'b0;
    end
  end
endmodule // pvr_ramp_timer
`default_nettype wire

// [hw/pvr_top.v]
// Output-stage configuration: volume ramp, sources, duty ceiling, delays, stop group
//
// The AXI4-Lite slave port is this design's own decision.
`include "pvr_defines.vh"
`default_nettype none
module pvr_top #(
  parameter ADDR_W        = 8,
  parameter DUTY_W        = 10,
  parameter STEP_W        = 16,
  parameter STEP_CYC_8K   = (`PVR_STEP_8K_US10 * 100) / `PVR_CLK_NS,
  parameter STEP_CYC_11K  = (`PVR_STEP_11K_US10 * 100) / `PVR_CLK_NS,
  parameter STEP_CYC_12K  = (`PVR_STEP_12K_US10 * 100) / `PVR_CLK_NS
) (
  input  wire              aclk,
  input  wire              aresetn,
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire [2:0]        s_axi_awprot,
  input  wire              s_axi_awvalid,
  output wire              s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output wire              s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire [2:0]        s_axi_arprot,
  input  wire              s_axi_arvalid,
  output wire              s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  input  wire [1:0]        fs_family,
  input  wire [DUTY_W-1:0] duty_req,
  output reg  [DUTY_W-1:0] duty_out,
  output reg  [7:0]        gain_ch1,
  output reg  [7:0]        gain_ch2,
  output reg  [7:0]        gain_ch3,
  output reg  [7:0]        gain_sub,
  output reg  [7:0]        gain_master,
  output wire              ramp_step,
  output wire              ramp_busy,
  output reg  [11:0]       ramp_steps,
  output reg  [7:0]        channel_edge_delay_ch1,
  output reg  [7:0]        channel_edge_delay_ch2,
  output reg  [7:0]        channel_edge_delay_ch1_inv,
  output reg  [7:0]        channel_edge_delay_ch2_inv,
  output reg  [3:0]        channel_run,
  output reg               hard_mute
);
  // ****************************************************************
  // Register storage
  // ****************************************************************
  reg  [7:0]        sys_ctrl2_ff;
  reg  [7:0]        master_vol_ff;
  reg  [7:0]        ch1_vol_ff;
  reg  [7:0]        ch2_vol_ff;
  reg  [7:0]        ch3_vol_ff;
  reg  [7:0]        volume_ramp_config_ff;
  reg  [7:0]        duty_ceiling_ff;
  reg  [7:0]        delay_ff [0:3];
  reg  [7:0]        stop_group_mask_ff;

  // ****************************************************************
  // Bus slave state
  // ****************************************************************
  reg               aw_held_ff;
  reg               w_held_ff;
  reg  [ADDR_W-1:0] awaddr_ff;
  reg  [31:0]       wdata_ff;
  reg  [3:0]        wstrb_ff;
  wire              do_write;
  wire [5:0]        wr_idx;
  wire [5:0]        rd_idx;
  wire              wr_hit;
  reg               rd_hit;
  reg  [7:0]        rd_val;
  wire [7:0]        wbyte;
  wire              wr_lane;

  // ****************************************************************
  // Pin synchroniser and ramp control
  // ****************************************************************
  reg  [1:0]        fam_meta_ff;
  reg  [1:0]        fam_ff;
  reg  [STEP_W-1:0] step_cyc;
  reg  [11:0]       nxt_ramp_steps;
  reg  [39:0]       target_ff;
  wire [39:0]       target_now;
  wire              ramp_start;
  reg  [DUTY_W-1:0] ceiling;
  integer           i;

  // ****************************************************************
  // Write channel: address and data taken in either order
  // ****************************************************************
  assign s_axi_awready = !aw_held_ff;
  assign s_axi_wready  = !w_held_ff;
  assign do_write      = aw_held_ff && w_held_ff && !s_axi_bvalid;
  assign wr_idx        = awaddr_ff[7:2];
  assign wbyte         = wdata_ff[7:0];
  assign wr_lane       = wstrb_ff[0];

  assign wr_hit = (wr_idx == `PVR_IDX_SYS_CTRL2) || (wr_idx == `PVR_IDX_MASTER_VOL) ||
                  (wr_idx == `PVR_IDX_CH1_VOL) || (wr_idx == `PVR_IDX_CH2_VOL) ||
                  (wr_idx == `PVR_IDX_CH3_VOL) || (wr_idx == `PVR_IDX_RAMP_CFG) ||
                  (wr_idx == `PVR_IDX_DUTY_CEIL) || (wr_idx == `PVR_IDX_STOP_GROUP) ||
                  ((wr_idx >= `PVR_IDX_DELAY_CH1) && (wr_idx <= `PVR_IDX_DELAY_CH2_INV));

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff   <= 1'b0;
      w_held_ff    <= 1'b0;
      awaddr_ff    <= {ADDR_W{1'b0}};
      wdata_ff     <= 32'h0000_0000;
      wstrb_ff     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `PVR_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_held_ff) begin
        aw_held_ff <= 1'b1;
        awaddr_ff  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held_ff) begin
        w_held_ff <= 1'b1;
        wdata_ff  <= s_axi_wdata;
        wstrb_ff  <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_ff   <= 1'b0;
        w_held_ff    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `PVR_RESP_OKAY : `PVR_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Register writes; only byte lane 0 carries data
  // ****************************************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      sys_ctrl2_ff          <= `PVR_RST_SYS_CTRL2;
      master_vol_ff         <= `PVR_RST_MASTER_VOL;
      ch1_vol_ff            <= `PVR_RST_CH_VOL;
      ch2_vol_ff            <= `PVR_RST_CH_VOL;
      ch3_vol_ff            <= `PVR_RST_CH_VOL;
      volume_ramp_config_ff <= `PVR_RST_RAMP_CFG;
      duty_ceiling_ff       <= `PVR_RST_DUTY_CEIL;
      delay_ff[0]           <= `PVR_RST_DELAY_A;
      delay_ff[1]           <= `PVR_RST_DELAY_B;
      delay_ff[2]           <= `PVR_RST_DELAY_A;
      delay_ff[3]           <= `PVR_RST_DELAY_B;
      stop_group_mask_ff    <= `PVR_RST_STOP_GROUP;
    end else if (do_write && wr_lane) begin
      case (wr_idx)
        `PVR_IDX_SYS_CTRL2:  sys_ctrl2_ff  <= wbyte;
        `PVR_IDX_MASTER_VOL: master_vol_ff <= wbyte;
        `PVR_IDX_CH1_VOL:    ch1_vol_ff    <= wbyte;
        `PVR_IDX_CH2_VOL:    ch2_vol_ff    <= wbyte;
        `PVR_IDX_CH3_VOL:    ch3_vol_ff    <= wbyte;
        `PVR_IDX_RAMP_CFG: begin
          // Source selects are frozen unless the master is at the mute code
          if (master_vol_ff == `PVR_MUTE_CODE) begin
            volume_ramp_config_ff[`PVR_RC_SUB_SEL] <= wbyte[`PVR_RC_SUB_SEL];
            volume_ramp_config_ff[`PVR_RC_CH3_SEL] <= wbyte[`PVR_RC_CH3_SEL];
          end
          // A reserved slew code is dropped so the ramp length stays defined
          if (!wbyte[`PVR_RC_SLEW_RSVD]) begin
            volume_ramp_config_ff[2:0] <= wbyte[2:0];
          end
        end
        `PVR_IDX_DUTY_CEIL:  duty_ceiling_ff <= wbyte & `PVR_DUTY_MASK;
        `PVR_IDX_STOP_GROUP: stop_group_mask_ff <= wbyte;
        default: begin
          for (i = 0; i < 4; i = i + 1) begin
            if (wr_idx == `PVR_IDX_DELAY_CH1 + i) begin
              delay_ff[i] <= wbyte & `PVR_DELAY_MASK;
            end
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Read channel: answer one cycle after the address is taken
  // ****************************************************************
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_idx        = s_axi_araddr[7:2];

  always @* begin
    rd_hit = 1'b1;
    rd_val = 8'h00;
    case (rd_idx)
      `PVR_IDX_SYS_CTRL2:     rd_val = sys_ctrl2_ff;
      `PVR_IDX_MASTER_VOL:    rd_val = master_vol_ff;
      `PVR_IDX_CH1_VOL:       rd_val = ch1_vol_ff;
      `PVR_IDX_CH2_VOL:       rd_val = ch2_vol_ff;
      `PVR_IDX_CH3_VOL:       rd_val = ch3_vol_ff;
      `PVR_IDX_RAMP_CFG:      rd_val = volume_ramp_config_ff & `PVR_RAMP_CFG_MASK;
      `PVR_IDX_DUTY_CEIL:     rd_val = duty_ceiling_ff;
      `PVR_IDX_DELAY_CH1:     rd_val = delay_ff[0];
      `PVR_IDX_DELAY_CH2:     rd_val = delay_ff[1];
      `PVR_IDX_DELAY_CH1_INV: rd_val = delay_ff[2];
      `PVR_IDX_DELAY_CH2_INV: rd_val = delay_ff[3];
      `PVR_IDX_STOP_GROUP:    rd_val = stop_group_mask_ff;
      default:                rd_hit = 1'b0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `PVR_RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h00_0000, rd_val};
      s_axi_rresp  <= rd_hit ? `PVR_RESP_OKAY : `PVR_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // Sample-rate family from the pins, then step pace and count
  // ****************************************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      fam_meta_ff <= 2'b00;
      fam_ff      <= 2'b00;
    end else begin
      fam_meta_ff <= fs_family;
      fam_ff      <= fam_meta_ff;
    end
  end

  always @* begin
    // Family code 11 is unused and paced like the 48 kHz family
    if (fam_ff == `PVR_FAM_8K) begin
      step_cyc = STEP_CYC_8K[STEP_W-1:0];
    end else if (fam_ff == `PVR_FAM_11K) begin
      step_cyc = STEP_CYC_11K[STEP_W-1:0];
    end else begin
      step_cyc = STEP_CYC_12K[STEP_W-1:0];
    end
    case (volume_ramp_config_ff[1:0])
      2'b00:   nxt_ramp_steps = `PVR_STEPS_512;
      2'b01:   nxt_ramp_steps = `PVR_STEPS_1024;
      2'b10:   nxt_ramp_steps = `PVR_STEPS_2048;
      default: nxt_ramp_steps = `PVR_STEPS_256;
    endcase
  end

  // ****************************************************************
  // Gain sources; a change of any target, mute included, restarts the ramp
  // ****************************************************************
  assign target_now = {master_vol_ff, ch1_vol_ff, ch2_vol_ff,
                       volume_ramp_config_ff[`PVR_RC_CH3_SEL] ? ch3_vol_ff : ch2_vol_ff,
                       volume_ramp_config_ff[`PVR_RC_SUB_SEL] ? ch3_vol_ff : ch1_vol_ff};
  assign ramp_start = (target_now != target_ff);

  always @(posedge aclk) begin
    if (!aresetn) begin
      target_ff   <= {`PVR_RST_MASTER_VOL, `PVR_RST_CH_VOL, `PVR_RST_CH_VOL,
                      `PVR_RST_CH_VOL, `PVR_RST_CH_VOL};
      gain_master <= `PVR_RST_MASTER_VOL;
      gain_ch1    <= `PVR_RST_CH_VOL;
      gain_ch2    <= `PVR_RST_CH_VOL;
      gain_ch3    <= `PVR_RST_CH_VOL;
      gain_sub    <= `PVR_RST_CH_VOL;
      ramp_steps  <= `PVR_STEPS_1024;
    end else begin
      target_ff   <= target_now;
      gain_master <= master_vol_ff;
      gain_ch1    <= ch1_vol_ff;
      gain_ch2    <= ch2_vol_ff;
      gain_ch3    <= target_now[15:8];
      gain_sub    <= target_now[7:0];
      ramp_steps  <= nxt_ramp_steps;
    end
  end

  pvr_ramp_timer #(
    .STEP_W (STEP_W),
    .CNT_W  (12)
  ) u_ramp (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .step_cycles (step_cyc),
    .step_total  (nxt_ramp_steps),
    .start       (ramp_start),
    .step_pulse  (ramp_step),
    .busy        (ramp_busy),
    .steps_left  ()
  );

  // ****************************************************************
  // Duty ceiling: full scale minus (code+1)/128 of full scale
  // ****************************************************************
  always @* begin
    ceiling = {DUTY_W{1'b1}} -
              ({{(DUTY_W-4){1'b0}}, 1'b0, duty_ceiling_ff[2:0]} << (DUTY_W-7)) -
              ({{(DUTY_W-1){1'b0}}, 1'b1} << (DUTY_W-7));
  end

  // ****************************************************************
  // Outputs to the modulator
  // ****************************************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      duty_out                   <= {DUTY_W{1'b0}};
      channel_edge_delay_ch1     <= `PVR_RST_DELAY_A;
      channel_edge_delay_ch2     <= `PVR_RST_DELAY_B;
      channel_edge_delay_ch1_inv <= `PVR_RST_DELAY_A;
      channel_edge_delay_ch2_inv <= `PVR_RST_DELAY_B;
      channel_run                <= 4'h0;
      hard_mute                  <= 1'b1;
    end else begin
      duty_out                   <= (duty_req > ceiling) ? ceiling : duty_req;
      // Low bits are held at zero, so the signed byte is already value times four
      channel_edge_delay_ch1     <= delay_ff[0];
      channel_edge_delay_ch2     <= delay_ff[1];
      channel_edge_delay_ch1_inv <= delay_ff[2];
      channel_edge_delay_ch2_inv <= delay_ff[3];
      hard_mute                  <= sys_ctrl2_ff[`PVR_SC2_SHUTDOWN];
      for (i = 0; i < 4; i = i + 1) begin
        channel_run[i] <= !sys_ctrl2_ff[`PVR_SC2_SHUTDOWN] &&
                          !(stop_group_mask_ff[i] && !sys_ctrl2_ff[`PVR_SC2_GROUP_OFF]);
      end
    end
  end
endmodule // pvr_top
`default_nettype wire

// [dv/pvr_chk.sv]
// Checker for the output-stage configuration block ports
`include "pvr_defines.vh"
`default_nettype none
module pvr_chk #(
  parameter int DUTY_W = 10
) (
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic [DUTY_W-1:0] duty_req,
  input wire logic [DUTY_W-1:0] duty_out,
  input wire logic              ramp_step,
  input wire logic [11:0]       ramp_steps,
  input wire logic [7:0]        channel_edge_delay_ch1,
  input wire logic [7:0]        channel_edge_delay_ch2,
  input wire logic [7:0]        channel_edge_delay_ch1_inv,
  input wire logic [7:0]        channel_edge_delay_ch2_inv,
  input wire logic [3:0]        channel_run,
  input wire logic              hard_mute,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic              s_axi_bvalid,
  input wire logic [1:0]        s_axi_bresp
);
  timeunit 1ns;
  timeprecision 1ps;
  // Highest ceiling is code 000, eight counts below full scale
  localparam int CEIL_MAX = (1 << DUTY_W) - 9;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_SLEW_LEN: assert property (ramp_steps inside {12'h100, 12'h200, 12'h400, 12'h800})
    else $error("ramp length outside table");
  AST_DUTY_MAX: assert property (duty_out <= CEIL_MAX)
    else $error("duty above highest ceiling");
  AST_DUTY_CLAMP: assert property (1'b1 |=> duty_out <= $past(duty_req))
    else $error("duty raised above request");
  AST_DELAY_LSB: assert property ((channel_edge_delay_ch1[1:0] | channel_edge_delay_ch2[1:0] |
    channel_edge_delay_ch1_inv[1:0] | channel_edge_delay_ch2_inv[1:0]) == 2'h0)
    else $error("delay not a multiple of four");
  AST_MUTE_STOP: assert property (hard_mute |-> channel_run == 4'h0)
    else $error("channel running in shutdown");
  AST_STEP_GAP: assert property (ramp_step |=> !ramp_step [*3])
    else $error("ramp steps too close");
  AST_RDATA_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  AST_BRESP: assert property (s_axi_bvalid |-> s_axi_bresp inside {`PVR_RESP_OKAY, `PVR_RESP_SLVERR})
    else $error("bad write response");
endmodule // pvr_chk
`default_nettype wire

// [dv/pvr_top_bench.sv]
// Self-checking bench for the output-stage configuration block
`include "pvr_defines.vh"
`default_nettype none
module pvr_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // Short step periods keep the ramp runs brief
  localparam int SC8 = 8, SC11 = 6, SC12 = 5;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr, r1, r2, r3, m;
  logic [31:0] wdata;
  logic [1:0]  fs_family;
  logic [9:0]  duty_req, v;
  wire         awready, wready, bvalid, arready, rvalid, ramp_step, ramp_busy, hard_mute;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [9:0]  duty_out;
  wire  [7:0]  g1, g2, g3, gs, gm, d1, d2, d3, d4;
  wire  [11:0] ramp_steps;
  wire  [3:0]  channel_run;
  int          err_total = 0, tests_run = 0, pulses = 0, cyc = 0, gap = 0, n, e;
  logic [5:0]  ri [12] = '{6'h05, 6'h07, 6'h08, 6'h09, 6'h0A, 6'h0E, 6'h10, 6'h11, 6'h12,
                           6'h13, 6'h14, 6'h19};
  logic [7:0]  rv [12] = '{8'h40, 8'hFF, 8'h30, 8'h30, 8'h30, 8'h01, 8'h02, 8'hAC, 8'h54,
                           8'hAC, 8'h54, 8'h30};
  logic [7:0]  bd [4] = '{8'hB8, 8'h60, 8'hA0, 8'h48};
  pvr_top #(.STEP_CYC_8K(SC8), .STEP_CYC_11K(SC11), .STEP_CYC_12K(SC12)) DUT (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .fs_family(fs_family), .duty_req(duty_req), .duty_out(duty_out), .gain_ch1(g1),
    .gain_ch2(g2), .gain_ch3(g3), .gain_sub(gs), .gain_master(gm), .ramp_step(ramp_step),
    .ramp_busy(ramp_busy), .ramp_steps(ramp_steps), .channel_edge_delay_ch1(d1),
    .channel_edge_delay_ch2(d2), .channel_edge_delay_ch1_inv(d3),
    .channel_edge_delay_ch2_inv(d4), .channel_run(channel_run), .hard_mute(hard_mute));
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  // Step pulse counter and spacing of the latest two pulses
  always @(posedge aclk) begin
    cyc <= ramp_step ? 1 : cyc + 1;
    if (ramp_step) begin
      pulses <= pulses + 1;
      gap <= cyc;
    end
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic timeout();
    err_total++;
    $display("[FAIL] t=%0t wait limit reached", $time);
    finish_test();
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    tests_run++;
    if (s !== x) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  // Address and data offered together, each dropped at its own acceptance
  task automatic wr(input logic [5:0] i, input logic [7:0] d, input logic [1:0] er = 2'h0);
    logic ta, tw, tb;
    tb = 1'b0;
    @(posedge aclk);
    awaddr <= {i, 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int k = 0; k < 40 && !tb; k++) begin
      @(negedge aclk);
      ta = awready;
      tw = wready;
      tb = bvalid;
      if (tb) chk(bresp, er);
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    if (!tb) timeout();
  endtask
  task automatic rd(input logic [5:0] i, input logic [7:0] x, input logic [1:0] er = 2'h0);
    logic tr, tv;
    tv = 1'b0;
    @(posedge aclk);
    araddr <= {i, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int k = 0; k < 40 && !tv; k++) begin
      @(negedge aclk);
      tr = arready;
      tv = rvalid;
      if (tv) chk({rresp, rdata}, {er, 24'h0, x});
      @(posedge aclk);
      if (tr) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    if (!tv) timeout();
  endtask
  task automatic wrd(input logic [5:0] i, input logic [7:0] d, input logic [7:0] x);
    wr(i, d);
    rd(i, x);
  endtask
  function automatic logic [7:0] dly(input int i);
    return i == 0 ? d1 : i == 1 ? d2 : i == 2 ? d3 : d4;
  endfunction
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {awaddr, araddr, wdata, fs_family, duty_req} = 60'h0;
    n = $urandom(45);
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    // ****************************************************************
    // Reset values and unmapped place
    // ****************************************************************
    for (int i = 0; i < 12; i++) rd(ri[i], rv[i]);
    chk({d1, d2, d3, d4}, 32'hAC54AC54);
    chk({hard_mute, channel_run, ramp_steps}, {1'b1, 4'h0, 12'h400});
    wr(6'h3F, 8'h5A, 2'h2);
    rd(6'h3F, 8'h00, 2'h2);
    $display("test reset done");
    // ****************************************************************
    // Slew codes, then pacing per family with a mute ramp among them
    // ****************************************************************
    for (int c = 0; c < 4; c++) begin
      wr(6'h0E, c[7:0]);
      @(negedge aclk);
      chk(ramp_steps, c == 0 ? 512 : c == 1 ? 1024 : c == 2 ? 2048 : 256);
    end
    wrd(6'h0E, 8'h07, 8'h03);
    for (int f = 0; f < 3; f++) begin
      @(posedge aclk);
      fs_family <= f[1:0];
      repeat (4) @(posedge aclk);
      // Baseline only: the pulse counter has a single driver in its own process
      e = pulses;
      wr(6'h07, f == 1 ? 8'hFF : 8'h20 + f[7:0]);
      repeat (3) @(negedge aclk);
      for (n = 0; n < 4000 && ramp_busy; n++) @(negedge aclk);
      if (ramp_busy) timeout();
      // The last pulse stands while busy falls; let the counter take it
      @(negedge aclk);
      chk(pulses - e, 256);
      chk(gap, f == 0 ? SC8 : f == 1 ? SC11 : SC12);
    end
    $display("test ramp done");
    // ****************************************************************
    // Volume sources, changed only while muted
    // ****************************************************************
    {r1, r2, r3} = $urandom;
    wr(6'h08, r1);
    wr(6'h09, r2);
    wr(6'h0A, r3);
    wrd(6'h0E, 8'h63, 8'h03);
    chk({g1, g2}, {r1, r2});
    chk({g3, gs}, {r2, r1});
    wr(6'h07, 8'hFF);
    wrd(6'h0E, 8'h63, 8'h63);
    chk({gm, g3, gs}, {8'hFF, r3, r3});
    wrd(6'h0E, 8'h23, 8'h23);
    chk({g3, gs}, {r3, r1});
    $display("test sources done");
    // ****************************************************************
    // Duty ceiling for every code
    // ****************************************************************
    for (int c = 0; c < 8; c++) begin
      wrd(6'h10, {5'h1F, c[2:0]}, {5'h0, c[2:0]});
      e = 1023 - (c + 1) * 8;
      for (int j = 0; j < 2; j++) begin
        v = j ? 10'h3FF : 10'($urandom_range(1023, 940));
        @(posedge aclk);
        duty_req <= v;
        @(posedge aclk);
        @(negedge aclk);
        chk(duty_out, v < e ? v : e);
      end
    end
    $display("test duty done");
    // ****************************************************************
    // Edge delays: random words, then the three-level set
    // ****************************************************************
    for (int i = 0; i < 8; i++) begin
      m = i < 4 ? 8'($urandom) : bd[i-4];
      wrd(6'h11 + 6'(i % 4), m, m & 8'hFC);
      chk(dly(i % 4), m & 8'hFC);
    end
    $display("test delay done");
    // ****************************************************************
    // Stop group on shutdown exit
    // ****************************************************************
    for (int i = 0; i < 3; i++) begin
      m = i == 0 ? 8'h3A : 8'h30 | (i == 2 ? 8'($urandom_range(15, 0)) : 8'h00);
      wrd(6'h19, m, m);
      wr(6'h05, 8'h00);
      @(negedge aclk);
      chk({hard_mute, channel_run}, {1'b0, ~m[3:0]});
      wr(6'h05, 8'h20);
      @(negedge aclk);
      chk(channel_run, 4'hF);
      wr(6'h05, 8'h40);
      @(negedge aclk);
      chk({hard_mute, channel_run}, 5'h10);
    end
    $display("test stop group done");
    finish_test();
  end
endmodule // pvr_top_bench
bind pvr_top pvr_chk #(.DUTY_W(DUTY_W)) u_chk (.aclk(aclk), .aresetn(aresetn),
  .duty_req(duty_req), .duty_out(duty_out), .ramp_step(ramp_step), .ramp_steps(ramp_steps),
  .channel_edge_delay_ch1(channel_edge_delay_ch1), .channel_edge_delay_ch2(channel_edge_delay_ch2),
  .channel_edge_delay_ch1_inv(channel_edge_delay_ch1_inv),
  .channel_edge_delay_ch2_inv(channel_edge_delay_ch2_inv), .channel_run(channel_run),
  .hard_mute(hard_mute), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .s_axi_bvalid(s_axi_bvalid), .s_axi_bresp(s_axi_bresp));
`default_nettype wire
